// ===== include/aclk_regs.svh
/*
  Register indices, field positions, reset values and slot counts for the
  codec register access block.
  Assumes it is included by bare name from the design and bench files.
*/
`ifndef ACLK_REGS_SVH
`define ACLK_REGS_SVH
// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ACL_IDX_INDEX    4'h4
`define ACL_IDX_CMD      4'h5
`define ACL_IDX_DATA_LO  4'h6
`define ACL_IDX_DATA_HI  4'h7
`define ACL_IDX_CFG      4'h8
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ACL_CMD_COLD     7
`define ACL_CMD_WARM     6
`define ACL_CMD_WRITE    5
`define ACL_CMD_READ     4
`define ACL_CMD_READY    3
`define ACL_CFG_I2S      7
`define ACL_CFG_PACKED   1
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ACL_RST_INDEX    7'h00
`define ACL_RST_DATA     16'h0000
`define ACL_RST_CFG      8'h00
// ----------------------------------------------------------------------
// frame timing in link bits, and AXI response codes
// ----------------------------------------------------------------------
`define ACL_LAST_SLOT    4'hC
`define ACL_TAG_TOP      5'h0F
`define ACL_SLOT_TOP     5'h13
`define ACL_RESP_OKAY    2'h0
`define ACL_RESP_SLVERR  2'h2
`endif

// ===== include/aclk_pkg.sv
/*
  Types shared by the codec register access design files.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package aclk_pkg;
  // command sequencer states, gray coded along idle-send-wait
  typedef enum logic [1:0] {
    ACL_IDLE = 2'h0,
    ACL_SEND = 2'h1,
    ACL_WAIT = 2'h3
  } acl_cmd_e;
endpackage
`default_nettype wire

// ===== rtl/acl_sync3.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes async_in comes from outside the clk domain.
*/
`default_nettype none
module acl_sync3 (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output var  logic stable
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // first stage feeds only the second; accept once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      stable <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) stable <= s3_reg;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/acl_frame.sv
/*
  Link frame engine: 13-slot frames, command out, status in.
  Assumes bit_rise/bit_fall are one-cycle pulses from the link bit clock.
*/
`default_nettype none
`include "aclk_regs.svh"
module acl_frame import aclk_pkg::*; (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        run,
  input  wire logic        bit_rise,
  input  wire logic        bit_fall,
  input  wire logic        sdata_in,
  input  wire logic        cmd_v,
  input  wire logic        cmd_rd,
  input  wire logic [6:0]  cmd_idx,
  input  wire logic [15:0] cmd_dat,
  input  wire logic [1:0]  codec_id,
  input  wire logic        pcm_v,
  input  wire logic [19:0] pcm_l,
  input  wire logic [19:0] pcm_r,
  output var  logic        sdata_out,
  output var  logic        frame_sync,
  output var  logic        cmd_sent,
  output var  logic        codec_ready,
  output var  logic        st_valid,
  output var  logic [6:0]  st_idx,
  output var  logic [15:0] st_data
);
  logic [3:0]  slot_reg;
  logic [3:0]  slot_next;
  logic [4:0]  pos_reg;
  logic [4:0]  pos_next;
  logic        wrap;
  logic        cur_v;
  logic        cur_rd;
  logic [6:0]  cur_idx;
  logic [15:0] cur_dat;
  logic [19:0] word;
  logic [19:0] in_sh;
  logic [19:0] in_val;
  logic [1:0]  tag_in;
  logic        out_bit;

  // ----------------------------------------------------------------------
  // slot and bit position counters
  // ----------------------------------------------------------------------
  always_comb begin
    wrap = 1'b0;
    slot_next = slot_reg;
    pos_next = pos_reg - 5'h01;
    if (pos_reg == 5'h00) begin
      if (slot_reg == `ACL_LAST_SLOT) begin
        wrap = 1'b1;
        slot_next = 4'h0;
        pos_next = `ACL_TAG_TOP;
      end else begin
        slot_next = slot_reg + 4'h1;
        pos_next = `ACL_SLOT_TOP;
      end
    end
  end

  // outgoing slot contents: tag, command address, command data, pcm
  always_comb begin
    case (slot_next)
      4'h0: word = {4'h0, 1'b1, cur_v, cur_v & ~cur_rd, pcm_v, pcm_v,
                    9'h000, codec_id};
      4'h1: word = {cur_rd, cur_idx, 12'h000};
      4'h2: word = {cur_dat, 4'h0};
      4'h3: word = pcm_l;
      4'h4: word = pcm_r;
      default: word = 20'h00000;
    endcase
    out_bit = word[pos_next];
  end

  // transmit side; a command is latched at frame start, never twice in a row
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_reg <= `ACL_LAST_SLOT;
      pos_reg <= 5'h00;
      sdata_out <= 1'b0;
      frame_sync <= 1'b0;
      cmd_sent <= 1'b0;
      cur_v <= 1'b0;
      cur_rd <= 1'b0;
      cur_idx <= 7'h00;
      cur_dat <= 16'h0000;
    end else if (!run) begin
      slot_reg <= `ACL_LAST_SLOT;
      pos_reg <= 5'h00;
      sdata_out <= 1'b0;
      frame_sync <= 1'b0;
      cmd_sent <= 1'b0;
      cur_v <= 1'b0;
    end else begin
      cmd_sent <= bit_rise & wrap & cur_v;
      if (bit_rise) begin
        slot_reg <= slot_next;
        pos_reg <= pos_next;
        sdata_out <= out_bit;
        frame_sync <= (slot_next == 4'h0);
        if (wrap) begin
          cur_v <= cmd_v & ~cur_v;
          cur_rd <= cmd_rd;
          cur_idx <= cmd_idx;
          cur_dat <= cmd_dat;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // receive side, sampled on the falling bit clock edge
  // ----------------------------------------------------------------------
  assign in_val = {in_sh[18:0], sdata_in};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_sh <= 20'h00000;
      codec_ready <= 1'b0;
      tag_in <= 2'h0;
      st_valid <= 1'b0;
      st_idx <= 7'h00;
      st_data <= 16'h0000;
    end else if (!run) begin
      codec_ready <= 1'b0;
      st_valid <= 1'b0;
    end else begin
      st_valid <= 1'b0;
      if (bit_fall) begin
        in_sh <= in_val;
        if (pos_reg == 5'h00) begin
          case (slot_reg)
            4'h0: begin
              codec_ready <= in_val[15];
              tag_in <= in_val[14:13];
            end
            4'h1: st_idx <= in_val[18:12];
            4'h2: begin
              st_valid <= &tag_in;
              st_data <= in_val[19:4];
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/acl_codec_access.sv
/*
  Codec register access: AXI4-Lite register slave, command sequencer,
  cold/warm reset and slave-mode bit clock for an external link codec.
  Assumes one 100 MHz clock; link pins are asynchronous to it.
*/
//
// Summary of operation
// - seven-bit codec register index, top bit zero
// - index, command, data ignored in converter mode
// - cold bit drives codec reset output active
// - warm bit holds frame sync high
// - cold reset works in converter mode too
// - slave mode drives bit clock at mclk rate
// - write bit starts codec register write
// - write bit busy until write done
// - read bit starts codec register read
// - read bit busy until data valid
// - read-only codec ready status bit
// - two-bit codec select, 00 primary
// - packed mode uses single serial output
// - primary codec pcm in slots 3,4
// - data port high byte at upper offset
// - data port low byte at lower offset
`default_nettype none
`include "aclk_regs.svh"
module acl_codec_access import aclk_pkg::*; #(
  parameter int ADDR_W = 6
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              link_bit_clock_in,
  output var  logic              link_bit_clock_out,
  output var  logic              link_bit_clock_oe,
  input  wire logic              external_master_clock_in,
  input  wire logic              codec_serial_data_in,
  output logic                   primary_serial_data_out,
  output var  logic              link_frame_sync_out,
  output var  logic              codec_reset_out_n,
  input  wire logic [19:0]       pcm_front_left,
  input  wire logic [19:0]       pcm_front_right,
  input  wire logic              pcm_valid
);
  logic [3:0]  aw_idx_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic [3:0]  ar_idx;
  logic [31:0] rd_word;
  logic        rd_map;
  logic        wr_map;
  logic        do_write;
  logic        wr_cmd;
  logic        ac;
  logic [6:0]  index_reg;
  logic [15:0] data_reg;
  logic [7:0]  cfg_reg;
  logic        cold_reg;
  logic        warm_reg;
  logic [1:0]  sel_reg;
  logic        slave_reg;
  logic        wr_busy;
  logic        rd_busy;
  logic        cmd_v;
  logic        cmd_rd;
  logic [6:0]  cmd_idx;
  logic [15:0] cmd_dat;
  acl_cmd_e    state;
  logic        abort;
  logic        rd_done;
  logic        bclk_q;
  logic        mclk_q;
  logic        sdin_q;
  logic        src_prev;
  logic        src;
  logic        frm_sync;
  logic        cmd_sent;
  logic        codec_ready;
  logic        st_valid;
  logic [6:0]  st_idx;
  logic [15:0] st_data;

  // ----------------------------------------------------------------------
  // pin synchronisers and link edge detection
  // ----------------------------------------------------------------------
  acl_sync3 u_bclk (.clk(clk), .reset_n(reset_n),
    .async_in(link_bit_clock_in), .stable(bclk_q));
  acl_sync3 u_mclk (.clk(clk), .reset_n(reset_n),
    .async_in(external_master_clock_in), .stable(mclk_q));
  acl_sync3 u_sdin (.clk(clk), .reset_n(reset_n),
    .async_in(codec_serial_data_in), .stable(sdin_q));

  // in slave mode we own the bit clock, so frame on our own copy of mclk
  assign src = slave_reg ? mclk_q : bclk_q;

  acl_frame u_frame (
    .clk(clk), .reset_n(reset_n), .run(ac & ~cold_reg),
    .bit_rise(src & ~src_prev), .bit_fall(~src & src_prev),
    .sdata_in(sdin_q), .cmd_v(cmd_v), .cmd_rd(cmd_rd),
    .cmd_idx(cmd_idx), .cmd_dat(cmd_dat),
    .codec_id(cfg_reg[`ACL_CFG_PACKED] ? 2'h0 : sel_reg),
    .pcm_v(pcm_valid), .pcm_l(pcm_front_left), .pcm_r(pcm_front_right),
    .sdata_out(primary_serial_data_out), .frame_sync(frm_sync),
    .cmd_sent(cmd_sent), .codec_ready(codec_ready), .st_valid(st_valid),
    .st_idx(st_idx), .st_data(st_data));

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  assign ar_idx = 4'(s_axi_araddr >> 2);
  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_cmd = do_write && aw_idx_q == `ACL_IDX_CMD && ws_q[0];
  assign ac = ~cfg_reg[`ACL_CFG_I2S];
  assign wr_map = aw_idx_q >= `ACL_IDX_INDEX && aw_idx_q <= `ACL_IDX_CFG;

  // read mux; unmapped words answer SLVERR with zero data
  always_comb begin
    rd_map = 1'b1;
    case (ar_idx)
      `ACL_IDX_INDEX:   rd_word = {25'h0, index_reg};
      `ACL_IDX_CMD:     rd_word = {24'h0, cold_reg, warm_reg, wr_busy,
                                   rd_busy, codec_ready, 1'b0, sel_reg};
      `ACL_IDX_DATA_LO: rd_word = {16'h0, data_reg};
      `ACL_IDX_DATA_HI: rd_word = {24'h0, data_reg[15:8]};
      `ACL_IDX_CFG:     rd_word = {24'h0, cfg_reg};
      default: begin
        rd_word = 32'h00000000;
        rd_map = 1'b0;
      end
    endcase
  end

  // address and data are taken in either order, answered after both
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACL_RESP_OKAY;
      aw_idx_q <= 4'h0;
      w_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx_q <= 4'(s_axi_awaddr >> 2);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `ACL_RESP_OKAY : `ACL_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ACL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_map ? `ACL_RESP_OKAY : `ACL_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  // index and converter config; index writes dropped in converter mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      index_reg <= `ACL_RST_INDEX;
      cfg_reg <= `ACL_RST_CFG;
    end else if (do_write && ws_q[0]) begin
      if (aw_idx_q == `ACL_IDX_INDEX && ac)
        index_reg <= w_q[6:0];
      if (aw_idx_q == `ACL_IDX_CFG) cfg_reg <= w_q[7:0];
    end
  end

  // data port: returned read data wins over a software write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg <= `ACL_RST_DATA;
    end else if (rd_done) begin
      data_reg <= st_data;
    end else if (do_write && ac) begin
      if (aw_idx_q == `ACL_IDX_DATA_LO && ws_q[0])
        data_reg[7:0] <= w_q[7:0];
      if (aw_idx_q == `ACL_IDX_DATA_LO && ws_q[1])
        data_reg[15:8] <= w_q[15:8];
      if (aw_idx_q == `ACL_IDX_DATA_HI && ws_q[0])
        data_reg[15:8] <= w_q[7:0];
    end
  end

  // cold/warm controls and codec select; cold works in every mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cold_reg <= 1'b0;
      warm_reg <= 1'b0;
      sel_reg <= 2'h0;
      slave_reg <= 1'b0;
    end else if (wr_cmd) begin
      cold_reg <= w_q[`ACL_CMD_COLD];
      warm_reg <= w_q[`ACL_CMD_WARM];
      if (ac) sel_reg <= w_q[1:0];
      // cold rising with warm held enters slave mode, else master
      if (w_q[`ACL_CMD_COLD] && !cold_reg)
        slave_reg <= warm_reg;
    end
  end

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  assign abort = cold_reg | ~ac;
  assign rd_done = state == ACL_WAIT && st_valid && st_idx == cmd_idx;

  // busy bits self-clear; write has priority if both are set at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ACL_IDLE;
      wr_busy <= 1'b0;
      rd_busy <= 1'b0;
      cmd_v <= 1'b0;
      cmd_rd <= 1'b0;
      cmd_idx <= 7'h00;
      cmd_dat <= 16'h0000;
    end else if (abort) begin
      state <= ACL_IDLE;
      wr_busy <= 1'b0;
      rd_busy <= 1'b0;
      cmd_v <= 1'b0;
    end else begin
      case (state)
        ACL_IDLE: begin
          if (wr_cmd && (w_q[`ACL_CMD_WRITE] || w_q[`ACL_CMD_READ])) begin
            wr_busy <= w_q[`ACL_CMD_WRITE];
            rd_busy <= ~w_q[`ACL_CMD_WRITE];
            cmd_rd <= ~w_q[`ACL_CMD_WRITE];
            cmd_v <= 1'b1;
            cmd_idx <= index_reg;
            cmd_dat <= data_reg;
            state <= ACL_SEND;
          end
        end
        ACL_SEND: begin
          if (cmd_sent) begin
            cmd_v <= 1'b0;
            if (cmd_rd) begin
              state <= ACL_WAIT;
            end else begin
              wr_busy <= 1'b0;
              state <= ACL_IDLE;
            end
          end
        end
        ACL_WAIT: begin
          if (rd_done) begin
            rd_busy <= 1'b0;
            state <= ACL_IDLE;
          end
        end
        default: state <= ACL_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // link pins
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      codec_reset_out_n <= 1'b0;
      link_frame_sync_out <= 1'b0;
      link_bit_clock_out <= 1'b0;
      link_bit_clock_oe <= 1'b0;
      src_prev <= 1'b0;
    end else begin
      codec_reset_out_n <= ~cold_reg;
      link_frame_sync_out <= (ac & warm_reg) | frm_sync;
      link_bit_clock_out <= mclk_q;
      link_bit_clock_oe <= slave_reg;
      src_prev <= src;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  cold_pin_a: assert property (wr_cmd |-> ##2
    codec_reset_out_n == !w_q[`ACL_CMD_COLD]) else $error("cold pin");
  warm_sync_a: assert property ((warm_reg && ac) |=> link_frame_sync_out)
    else $error("warm sync low");
  conv_ignore_a: assert property ((do_write && !ac) |=>
    $stable(index_reg) && $stable(data_reg) && $stable(sel_reg))
    else $error("converter mode write took effect");
  wr_start_a: assert property ((wr_cmd && !abort && state == ACL_IDLE &&
    w_q[`ACL_CMD_WRITE]) |=> wr_busy && cmd_v)
    else $error("write not started");
  wr_done_a: assert property ($fell(wr_busy) |->
    $past(cmd_sent) || $past(abort)) else $error("write cleared early");
  rd_done_a: assert property ($fell(rd_busy) |->
    $past(rd_done) || $past(abort)) else $error("read cleared early");
  rd_load_a: assert property ($past(rd_done) |->
    data_reg == $past(st_data) && !rd_busy) else $error("read data lost");
  slave_clk_a: assert property ((slave_reg && $rose(mclk_q)) |=>
    link_bit_clock_out && link_bit_clock_oe)
    else $error("slave bit clock");

  wr_cycle_c: cover property ($fell(wr_busy) && !abort);
  rd_cycle_c: cover property (rd_done);
  slave_in_c: cover property ($rose(slave_reg));
endmodule
`default_nettype wire

// ===== sim/acl_codec_model.sv
/*
  Link codec model: bit clock, frame capture, status reply.
  Assumes sync marks slot0 and data moves on bit clock edges.
*/
`default_nettype none
module acl_codec_model (
  input  wire logic        rst_n,
  input  wire logic        oe,
  input  wire logic        bclk,
  input  wire logic        sync,
  input  wire logic        sdo,
  output var  logic        bclk_drv,
  output var  logic        sdi,
  output var  logic [23:0] got_cmd,
  output var  logic [19:0] got_pcm,
  output var  logic [1:0]  got_id
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // frame tracking
  // ---------------------------------------------------------------
  logic [255:0] rx;
  logic [255:0] tx;
  logic [6:0]   ridx;
  logic         ps;
  logic         pend;
  int           k;
  // clock stands still in reset and while the block drives it
  initial begin
    {bclk_drv, sdi, ps, pend, tx, got_cmd, got_pcm, ridx, got_id} = '0;
    k = 0;
    #7;
    forever #80 bclk_drv = rst_n & ~oe & ~bclk_drv;
  end
  // sample on falling edge; answer a read in the next frame
  always @(negedge bclk) begin
    k = (sync && !ps) ? 0 : (k + 1) % 256;
    ps = sync;
    rx[255-k] = sdo;
    if (k == 255) begin
      got_pcm = rx[199:180];
      if (rx[254]) begin
        got_cmd = {rx[239:232], rx[219:204]};
        got_id = rx[241:240];
        pend = rx[239];
        ridx = rx[238:232];
      end
      tx = '0;
      tx[255] = 1'b1;
      if (pend) begin
        tx[254:253] = 2'h3;
        tx[238:232] = ridx;
        tx[219:204] = {8'hA5, 1'b0, ridx};
      end
      pend = 1'b0;
    end
  end
  // status bits change after rising edges
  always @(posedge bclk) sdi <= tx[255-((k+1)%256)];
endmodule
`default_nettype wire

// ===== sim/aclink_codec_register_access_bench.sv
/*
  Bench for acl_codec_access with a codec model.
  Assumes package, header and design files compile first.
*/
`default_nettype none
`include "aclk_regs.svh"
module aclink_codec_register_access_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // wiring
  // ---------------------------------------------------------------
  logic        clk, reset_n, awv, wv, bre, arv, rre, mclk;
  logic        awr, wrd, bv, arr, rv, bco, oe, sdo, sync, rsn, bcd, sdi;
  logic [5:0]  awa, ara;
  logic [31:0] wd, rdt, v;
  logic [1:0]  br, rr, r, gid;
  logic [23:0] gcmd;
  logic [19:0] gpcm;
  int          n_fail, tests_run, ca, cb, i;
  wire logic   bcw = oe ? bco : bcd;
  localparam logic [5:0]  RA [4] = '{6'h10, 6'h18, 6'h1C, 6'h00};
  localparam logic [31:0] RW [4] = '{32'hFF, 32'h1234, 32'h56, 32'h1};
  localparam logic [31:0] RE [4] = '{32'h7F, 32'h1234, 32'h56, 32'h0};
  localparam logic [1:0]  RR [4] = '{`ACL_RESP_OKAY, `ACL_RESP_OKAY,
                                     `ACL_RESP_OKAY, `ACL_RESP_SLVERR};
  acl_codec_access i_acl_codec_access (.clk, .reset_n,
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .link_bit_clock_in(bcw),
    .link_bit_clock_out(bco), .link_bit_clock_oe(oe),
    .external_master_clock_in(mclk), .codec_serial_data_in(sdi),
    .primary_serial_data_out(sdo), .link_frame_sync_out(sync),
    .codec_reset_out_n(rsn), .pcm_front_left(20'h12345),
    .pcm_front_right(20'h0ABCD), .pcm_valid(1'b1));
  acl_codec_model i_acl_codec_model (.rst_n(rsn), .oe, .bclk(bcw),
    .sync, .sdo, .bclk_drv(bcd), .sdi, .got_cmd(gcmd), .got_pcm(gpcm),
    .got_id(gid));
  // clocks; master clock phase unrelated to clk
  initial begin clk = 0; forever #5 clk = ~clk; end
  initial begin mclk = 0; #3; forever #80 mclk = ~mclk; end
  always @(posedge bco) ca++;
  always @(posedge mclk) cb++;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 0;
      if (wv && wrd) wv <= 0;
    end while (!bv && n < 999);
    r = br; bre <= 0;
    // one more edge so pins launched by this write have settled
    @(posedge clk);
    if (n >= 999) n_fail++;
  endtask
  task automatic rd(input logic [5:0] a);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a; arv <= 1; rre <= 1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 0;
    end while (!rv && n < 999);
    v = rdt; r = rr; rre <= 0;
    if (n >= 999) n_fail++;
  endtask
  // a busy or ready bit is polled, bounded by a count of reads
  task automatic poll(input int b, input logic e);
    int n;
    n = 0;
    do begin rd(6'h14); n++; end while (v[b] !== e && n < 9000);
    if (n >= 9000) n_fail++;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {reset_n, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
    {n_fail, tests_run, ca, cb} = '0;
    repeat (5) @(posedge clk);
    reset_n <= 1;
    rd(6'h10); chk("index reset", v, 0);
    rd(6'h18); chk("data reset", v, 0);
    poll(3, 1);
    for (i = 0; i < 4; i++) begin
      wr(RA[i], RW[i]); chk("wresp", 32'(r), 32'(RR[i]));
      rd(RA[i]); chk("rdata", v, RE[i]);
      chk("rresp", 32'(r), 32'(RR[i]));
    end
    wr(6'h10, 32'h12); wr(6'h18, 32'hBEEF); wr(6'h14, 32'h20);
    rd(6'h14); chk("write busy", 32'(v[5]), 1);
    poll(5, 0);
    chk("command", 32'(gcmd), 32'h12BEEF);
    chk("pcm slot", 32'(gpcm), 32'h12345);
    // packed mode forces the primary id whatever the select holds
    wr(6'h20, 32'h02); wr(6'h14, 32'h23); poll(5, 0);
    chk("packed id", 32'(gid), 0);
    wr(6'h20, 0);
    wr(6'h10, 32'h2A); wr(6'h14, 32'h10);
    rd(6'h14); chk("read busy", 32'(v[4]), 1);
    poll(4, 0);
    rd(6'h18); chk("read data", v, 32'hA52A);
    wr(6'h20, 32'h80); wr(6'h10, 32'h05);
    rd(6'h10); chk("converter idx", v, 32'h2A);
    wr(6'h14, 32'h80); chk("cold conv", 32'(rsn), 0);
    wr(6'h14, 0); wr(6'h20, 0);
    // slave entry: warm, warm with cold, then clear
    wr(6'h14, 32'h40);
    for (i = 0; i < 4; i++) begin
      repeat (900) @(posedge clk);
      chk("warm sync", 32'(sync), 1);
    end
    wr(6'h14, 32'hC0); chk("cold", 32'(rsn), 0);
    wr(6'h14, 0); chk("cold off", 32'(rsn), 1);
    chk("slave oe", 32'(oe), 1);
    ca = 0; cb = 0;
    repeat (400) @(posedge clk);
    chk("bclk rate", 32'((ca - cb) * (ca - cb) <= 1 && cb > 20), 1);
    wr(6'h14, 32'h80); wr(6'h14, 0);
    chk("master oe", 32'(oe), 0);
    finish_test;
  end
  // whole run is well under this span
  initial begin #900000; n_fail++; finish_test; end
endmodule
`default_nettype wire
